// ---- hw/swd_top.v ----
// Behaviour
// - after any reset the watchdog enable bit is set
// - enable bit cleared stops counting and stops reset generation
// - any write to reset cause address clears counter, status unchanged
// - enabled counter reaching selected overflow count raises system reset
// - clock select 0 picks slow 1 kHz source, 1 picks bus clock
// - slow source: 2^5 cycles short, 2^8 cycles long timeout
// - bus clock: 2^13 short, 2^18 long; reset default bus, long
// - option registers accept only one write after reset
// - first write to each option register also clears the counter
// - counter holds its value in background debug mode
// - bus clock: counter holds in stop and resumes after it
// - slow source: counter zeroed on stop entry, restarts from zero
// - watchdog reset recorded in its own reset cause bit
`include "swd_defs.vh"
`default_nettype none

module swd_top #(
    parameter integer LPO_DIV = `SWD_LPO_DIV
) (
    input  wire        CLK,
    input  wire        RST,
    input  wire [7:0]  AWADDR,
    input  wire        AWVALID,
    output reg         AWREADY,
    input  wire [31:0] WDATA,
    input  wire [3:0]  WSTRB,
    input  wire        WVALID,
    output reg         WREADY,
    output reg  [1:0]  BRESP,
    output reg         BVALID,
    input  wire        BREADY,
    input  wire [7:0]  ARADDR,
    input  wire        ARVALID,
    output reg         ARREADY,
    output reg  [31:0] RDATA,
    output reg  [1:0]  RRESP,
    output reg         RVALID,
    input  wire        RREADY,
    input  wire        DEBUG_MODE,
    input  wire        STOP_MODE,
    output reg         WDOG_RESET,
    output reg         IRQ
);

    // pin synchronisers: bit 0 debug, bit 1 stop
    reg  [1:0]            sync1_q;
    reg  [1:0]            sync2_q;

    // write channel holding
    reg                   aw_full_q;
    reg  [7:0]            aw_addr_q;
    reg                   w_full_q;
    reg  [31:0]           w_data_q;
    reg  [3:0]            w_strb_q;

    // configuration and status
    reg                   en_q;
    reg                   tsel_q;
    reg                   csel_q;
    reg                   lock1_q;
    reg                   lock2_q;
    reg                   cause_wd_q;
    reg                   cause_por_q;
    reg  [1:0]            ist_q;
    reg  [1:0]            imask_q;

    wire                  aw_take;
    wire                  w_take;
    wire                  wr_fire;
    wire                  ar_take;
    wire                  aw_full_d;
    wire                  w_full_d;
    wire                  bvalid_d;
    wire                  rvalid_d;
    wire                  lane0;
    wire                  wr_cause;
    wire                  wr_opt1;
    wire                  wr_opt2;
    wire                  wr_ist;
    wire                  wr_imask;
    wire                  wr_hit;
    wire                  opt1_first;
    wire                  opt2_first;
    wire                  cnt_clear;
    wire                  lpo_tick;
    wire                  ovf;
    wire                  warn;
    wire [`SWD_CNT_W-1:0] count;
    wire [1:0]            ev;
    wire [1:0]            w1c;
    wire [1:0]            ist_d;

    reg  [31:0]           rd_data;
    reg                   rd_hit;

    // ---- axi4-lite handshakes
    assign aw_take   = AWVALID & AWREADY;
    assign w_take    = WVALID & WREADY;
    assign wr_fire   = aw_full_q & w_full_q & ~BVALID;
    assign ar_take   = ARVALID & ARREADY;
    assign aw_full_d = (aw_full_q & ~wr_fire) | aw_take;
    assign w_full_d  = (w_full_q & ~wr_fire) | w_take;
    assign bvalid_d  = wr_fire | (BVALID & ~BREADY);
    assign rvalid_d  = ar_take | (RVALID & ~RREADY);

    // ---- write decode
    assign lane0    = w_strb_q[0];
    assign wr_cause = wr_fire & (aw_addr_q == `SWD_OFF_CAUSE);
    assign wr_opt1  = wr_fire & (aw_addr_q == `SWD_OFF_OPT_ONE);
    assign wr_opt2  = wr_fire & (aw_addr_q == `SWD_OFF_OPT_TWO);
    assign wr_ist   = wr_fire & (aw_addr_q == `SWD_OFF_INT_STAT);
    assign wr_imask = wr_fire & (aw_addr_q == `SWD_OFF_INT_MASK);
    assign wr_hit   = wr_cause | wr_opt1 | wr_opt2 | wr_ist | wr_imask |
                      (wr_fire & (aw_addr_q == `SWD_OFF_COUNT));

    assign opt1_first = wr_opt1 & lane0 & ~lock1_q;
    assign opt2_first = wr_opt2 & lane0 & ~lock2_q;

    // service write, first option writes, watchdog reset all zero the count
    assign cnt_clear = wr_cause | opt1_first | opt2_first | WDOG_RESET;

    // ---- interrupt status, set wins over clear
    assign ev = {ovf, warn};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ist
            assign w1c[gi]   = wr_ist & lane0 & w_data_q[gi];
            assign ist_d[gi] = (ist_q[gi] & ~w1c[gi]) | ev[gi];
        end
    endgenerate

    swd_tick #(
        .DIV      (LPO_DIV)
    ) u_tick (
        .clk      (CLK),
        .rst      (RST),
        .tick     (lpo_tick)
    );

    swd_counter u_counter (
        .clk      (CLK),
        .rst      (RST),
        .clear    (cnt_clear),
        .enable   (en_q),
        .lpo_tick (lpo_tick),
        .clk_sel  (csel_q),
        .tmo_sel  (tsel_q),
        .debug    (sync2_q[0]),
        .stop     (sync2_q[1]),
        .count    (count),
        .overflow (ovf),
        .warn     (warn)
    );

    // ---- read mux
    always @* begin
        rd_data = 32'h0;
        rd_hit  = 1'b1;
        case (ARADDR)
            `SWD_OFF_CAUSE: begin
                rd_data[`SWD_BIT_CAUSE_WD]  = cause_wd_q;
                rd_data[`SWD_BIT_CAUSE_POR] = cause_por_q;
            end
            `SWD_OFF_OPT_ONE: begin
                rd_data[`SWD_BIT_ENABLE]  = en_q;
                rd_data[`SWD_BIT_TIMEOUT] = tsel_q;
            end
            `SWD_OFF_OPT_TWO: begin
                rd_data[`SWD_BIT_CLKSEL] = csel_q;
            end
            `SWD_OFF_COUNT: begin
                rd_data[`SWD_CNT_W-1:0] = count;
            end
            `SWD_OFF_INT_STAT: begin
                rd_data[1:0] = ist_q;
            end
            `SWD_OFF_INT_MASK: begin
                rd_data[1:0] = imask_q;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ---- bus channel registers
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            sync1_q   <= 2'h0;
            sync2_q   <= 2'h0;
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_full_q  <= 1'b0;
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
            AWREADY   <= 1'b1;
            WREADY    <= 1'b1;
            BVALID    <= 1'b0;
            BRESP     <= `SWD_RESP_OKAY;
            ARREADY   <= 1'b1;
            RVALID    <= 1'b0;
            RDATA     <= 32'h0;
            RRESP     <= `SWD_RESP_OKAY;
        end else begin
            sync1_q   <= {STOP_MODE, DEBUG_MODE};
            sync2_q   <= sync1_q;
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            AWREADY   <= ~aw_full_d;
            WREADY    <= ~w_full_d;
            BVALID    <= bvalid_d;
            ARREADY   <= ~rvalid_d;
            RVALID    <= rvalid_d;
            if (aw_take) begin
                aw_addr_q <= AWADDR;
            end
            if (w_take) begin
                w_data_q <= WDATA;
                w_strb_q <= WSTRB;
            end
            if (wr_fire) begin
                BRESP <= wr_hit ? `SWD_RESP_OKAY : `SWD_RESP_SLVERR;
            end
            if (ar_take) begin
                RDATA <= rd_data;
                RRESP <= rd_hit ? `SWD_RESP_OKAY : `SWD_RESP_SLVERR;
            end
        end
    end

    // ---- write-once options; a watchdog reset restores defaults and reopens them
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            en_q    <= `SWD_RST_ENABLE;
            tsel_q  <= `SWD_RST_TIMEOUT;
            csel_q  <= `SWD_RST_CLKSEL;
            lock1_q <= 1'b0;
            lock2_q <= 1'b0;
        end else if (ovf) begin
            en_q    <= `SWD_RST_ENABLE;
            tsel_q  <= `SWD_RST_TIMEOUT;
            csel_q  <= `SWD_RST_CLKSEL;
            lock1_q <= 1'b0;
            lock2_q <= 1'b0;
        end else begin
            if (opt1_first) begin
                en_q    <= w_data_q[`SWD_BIT_ENABLE];
                tsel_q  <= w_data_q[`SWD_BIT_TIMEOUT];
                lock1_q <= 1'b1;
            end
            if (opt2_first) begin
                csel_q  <= w_data_q[`SWD_BIT_CLKSEL];
                lock2_q <= 1'b1;
            end
        end
    end

    // ---- reset cause, not writable; watchdog overflow sets WD and clears POR, block reset restores POR
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            cause_wd_q  <= 1'b0;
            cause_por_q <= 1'b1;
        end else if (ovf) begin
            cause_wd_q  <= 1'b1;
            cause_por_q <= 1'b0;
        end
    end

    // ---- watchdog reset pulse
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            WDOG_RESET <= 1'b0;
        end else begin
            WDOG_RESET <= ovf;
        end
    end

    // ---- interrupt status, mask and level output
    always @(posedge CLK or posedge RST) begin
        if (RST) begin
            ist_q   <= 2'h0;
            imask_q <= 2'h0;
            IRQ     <= 1'b0;
        end else begin
            ist_q <= ist_d;
            IRQ   <= |(ist_d & imask_q);
            if (wr_imask & lane0) begin
                imask_q <= w_data_q[1:0];
            end
        end
    end

endmodule // swd_top

`default_nettype wire

// ---- hw/swd_defs.vh ----
`ifndef SWD_DEFS_VH
`define SWD_DEFS_VH

// register byte offsets
`define SWD_OFF_CAUSE      8'h00
`define SWD_OFF_OPT_ONE    8'h04
`define SWD_OFF_OPT_TWO    8'h08
`define SWD_OFF_COUNT      8'h0C
`define SWD_OFF_INT_STAT   8'h10
`define SWD_OFF_INT_MASK   8'h14

// field positions
`define SWD_BIT_ENABLE     0
`define SWD_BIT_TIMEOUT    1
`define SWD_BIT_CLKSEL     0
`define SWD_BIT_CAUSE_WD   0
`define SWD_BIT_CAUSE_POR  1
`define SWD_BIT_EV_WARN    0
`define SWD_BIT_EV_WDRST   1

// reset values
`define SWD_RST_ENABLE     1'b1
`define SWD_RST_TIMEOUT    1'b1
`define SWD_RST_CLKSEL     1'b1

// axi responses
`define SWD_RESP_OKAY      2'h0
`define SWD_RESP_SLVERR    2'h2

// overflow terminal values (overflow count minus one)
`define SWD_CNT_W          18
`define SWD_TERM_LPO_SHORT 18'h0001F
`define SWD_TERM_LPO_LONG  18'h000FF
`define SWD_TERM_BUS_SHORT 18'h01FFF
`define SWD_TERM_BUS_LONG  18'h3FFFF

// slow source period and system clock period
`define SWD_LPO_PERIOD_NS  1000000
`define SWD_CLK_PERIOD_NS  40
`define SWD_LPO_DIV        (`SWD_LPO_PERIOD_NS / `SWD_CLK_PERIOD_NS)

`endif

// ---- hw/swd_tick.v ----
`include "swd_defs.vh"
`default_nettype none

module swd_tick #(
    parameter integer DIV = `SWD_LPO_DIV
) (
    input  wire clk,
    input  wire rst,
    output reg  tick
);

    reg [31:0] cnt_q;

    // one-cycle enable once per slow period
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 32'h0;
            tick  <= 1'b0;
        end else if (cnt_q == DIV - 1) begin
            cnt_q <= 32'h0;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick  <= 1'b0;
        end
    end

endmodule // swd_tick

`default_nettype wire

// ---- hw/swd_counter.v ----
`include "swd_defs.vh"
`default_nettype none

module swd_counter (
    input  wire                     clk,
    input  wire                     rst,
    input  wire                     clear,
    input  wire                     enable,
    input  wire                     lpo_tick,
    input  wire                     clk_sel,
    input  wire                     tmo_sel,
    input  wire                     debug,
    input  wire                     stop,
    output reg  [`SWD_CNT_W-1:0]    count,
    output wire                     overflow,
    output wire                     warn
);

    reg                   stop_q;
    reg  [`SWD_CNT_W-1:0] term;
    wire                  stop_entry;
    wire                  step;

    always @* begin
        case ({clk_sel, tmo_sel})
            2'b00:   term = `SWD_TERM_LPO_SHORT;
            2'b01:   term = `SWD_TERM_LPO_LONG;
            2'b10:   term = `SWD_TERM_BUS_SHORT;
            default: term = `SWD_TERM_BUS_LONG;
        endcase
    end

    assign stop_entry = stop & ~stop_q;
    // bus clock counts every cycle, slow source on its tick
    assign step = enable & ~debug & ~stop & (clk_sel | lpo_tick);
    assign overflow = step & (count == term);
    assign warn     = step & (count == (term >> 1));

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            stop_q <= 1'b0;
            count  <= {`SWD_CNT_W{1'b0}};
        end else begin
            stop_q <= stop;
            if (clear | overflow) begin
                count <= {`SWD_CNT_W{1'b0}};
            end else if (~clk_sel & (stop_entry | stop)) begin
                count <= {`SWD_CNT_W{1'b0}};
            end else if (step) begin
                count <= count + {{(`SWD_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // swd_counter

`default_nettype wire

// ---- verification/swd_monitor.sv ----
`default_nettype none
module swd_monitor #(
    parameter integer LPO_DIV = 25000
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic DEBUG_MODE,
    input wire logic STOP_MODE,
    input wire logic WDOG_RESET
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MINC = (31 * LPO_DIV < 8190) ? 31 * LPO_DIV - 4 : 8186;
    // cycles since reset or since the last watchdog pulse
    int gap_q;
    always @(posedge CLK or posedge RST) begin
        if (RST) gap_q <= 0;
        else if (WDOG_RESET) gap_q <= 0;
        else if (gap_q < 9000) gap_q <= gap_q + 1;
    end
    default clocking mcb @(posedge CLK); endclocking
    default disable iff (RST);
    property p_pulse; WDOG_RESET |=> !WDOG_RESET; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse too long");
    property p_gap; $rose(WDOG_RESET) |-> gap_q >= MINC; endproperty
    a_gap: assert property (p_gap) else $error("early reset");
    property p_dbg; DEBUG_MODE [*6] |-> !WDOG_RESET; endproperty
    a_dbg: assert property (p_dbg) else $error("reset in debug");
    property p_stop; STOP_MODE [*6] |-> !WDOG_RESET; endproperty
    a_stop: assert property (p_stop) else $error("reset in stop");
    property p_bans; AWVALID && AWREADY && WVALID && WREADY && !BVALID |-> ##2 BVALID; endproperty
    a_bans: assert property (p_bans) else $error("no write answer");
    property p_awbusy; AWVALID && AWREADY |=> !AWREADY; endproperty
    a_awbusy: assert property (p_awbusy) else $error("address not held");
    property p_rans; ARVALID && ARREADY |=> RVALID; endproperty
    a_rans: assert property (p_rans) else $error("no read answer");
    property p_arbusy; ARVALID && ARREADY |=> !ARREADY; endproperty
    a_arbusy: assert property (p_arbusy) else $error("read not held");
    c_wdog: cover property (WDOG_RESET);
    c_dbg: cover property (DEBUG_MODE [*6]);
    c_stop: cover property (STOP_MODE [*6]);
endmodule // swd_monitor
bind swd_top swd_monitor #(.LPO_DIV(LPO_DIV)) u_mon (
    .CLK, .RST, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID,
    .ARVALID, .ARREADY, .RVALID, .DEBUG_MODE, .STOP_MODE, .WDOG_RESET
);
`default_nettype wire

// ---- verification/testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = 4;
    logic        CLK = 1'b0, RST = 1'b1;
    logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0, rv;
    logic [3:0]  WSTRB = 4'hF;
    logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0;
    logic        RREADY = 1'b0, DEBUG_MODE = 1'b0, STOP_MODE = 1'b0;
    logic [1:0]  rr;
    wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, WDOG_RESET, IRQ;
    wire  [1:0]  BRESP, RRESP;
    wire  [31:0] RDATA;
    int          error_cnt = 0, check_count = 0, cyc = 0;
    swd_top #(.LPO_DIV(DIV)) u_dut (
        .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
        .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
        .DEBUG_MODE(DEBUG_MODE), .STOP_MODE(STOP_MODE), .WDOG_RESET(WDOG_RESET), .IRQ(IRQ)
    );
    always #20 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic rst_dut;
        RST <= 1'b1;
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge CLK);
        AWADDR <= ad;
        WDATA <= d;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge CLK);
            ta = ta | AWREADY;
            tw = tw | WREADY;
            if (ta) AWVALID <= 1'b0;
            if (tw) WVALID <= 1'b0;
        end
        while (BVALID !== 1'b1) @(posedge CLK);
        rr = BRESP;
        BREADY <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad);
        @(posedge CLK);
        ARADDR <= ad;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do @(posedge CLK); while (ARREADY !== 1'b1);
        ARVALID <= 1'b0;
        do @(posedge CLK); while (RVALID !== 1'b1);
        rv = RDATA;
        rr = RRESP;
        RREADY <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
        rd(ad);
        chk($sformatf("reg %h", ad), rv, e);
    endtask
    task automatic t_defaults;
        rchk(8'h00, 32'h2);
        rchk(8'h04, 32'h3);
        rchk(8'h08, 32'h1);
        rd(8'h40);
        chk("rresp", rr, 2'h2);
    endtask
    task automatic t_ovf(input logic cs, input logic tm, input int lo, input int hi,
                         input logic e);
        int n;
        n = 0;
        rst_dut();
        wr(8'h14, 32'h2);
        wr(8'h08, {31'h0, cs});
        wr(8'h04, {30'h0, tm, 1'b1});
        while (WDOG_RESET !== 1'b1 && n < hi) begin
            @(posedge CLK);
            n++;
        end
        chk("overflow", {WDOG_RESET === 1'b1, n >= lo}, {e, 1'b1});
    endtask
    task automatic t_after;
        rchk(8'h00, 32'h1);
        rchk(8'h04, 32'h3);
        chk("irq", IRQ, 1'b1);
        wr(8'h10, 32'h2);
        repeat (2) @(posedge CLK);
        chk("irq", IRQ, 1'b0);
        rchk(8'h10, 32'h1);
    endtask
    task automatic t_service;
        rst_dut();
        repeat (100) @(posedge CLK);
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h0C);
        chk("serviced", rv < 12, 1'b1);
        rchk(8'h00, 32'h2);
        WSTRB <= 4'hE;
        wr(8'h04, 32'h0);
        WSTRB <= 4'hF;
        rchk(8'h04, 32'h3);
        wr(8'h04, 32'h0);
        wr(8'h04, 32'h3);
        chk("locked bresp", rr, 2'h0);
        rchk(8'h04, 32'h0);
        wr(8'h44, 32'h0);
        chk("unmapped bresp", rr, 2'h2);
        repeat (50) @(posedge CLK);
        rchk(8'h0C, 32'h0);
    endtask
    task automatic frz;
        repeat (4) @(posedge CLK);
        rd(8'h0C);
        chk("count rresp", rr, 2'h0);
        repeat (20) @(posedge CLK);
        rchk(8'h0C, rv);
    endtask
    task automatic t_modes;
        logic [31:0] hold;
        rst_dut();
        repeat (100) @(posedge CLK);
        wr(8'h08, 32'h1);
        rd(8'h0C);
        chk("first opt", rv < 12, 1'b1);
        DEBUG_MODE <= 1'b1;
        frz();
        DEBUG_MODE <= 1'b0;
        STOP_MODE <= 1'b1;
        frz();
        STOP_MODE <= 1'b0;
        hold = rv;
        repeat (10) @(posedge CLK);
        rd(8'h0C);
        chk("resume", rv > hold + 4 && rv < hold + 14, 1'b1);
        rst_dut();
        wr(8'h08, 32'h0);
        repeat (10 * DIV) @(posedge CLK);
        STOP_MODE <= 1'b1;
        repeat (4) @(posedge CLK);
        rchk(8'h0C, 32'h0);
        STOP_MODE <= 1'b0;
        repeat (3 * DIV) @(posedge CLK);
        rd(8'h0C);
        chk("restart", rv > 0 && rv < 6, 1'b1);
    endtask
    initial begin
        rst_dut();
        t_defaults();
        t_ovf(1'b0, 1'b0, 31 * DIV - 2, 32 * DIV + 3, 1'b1);
        t_after();
        t_ovf(1'b0, 1'b1, 255 * DIV - 2, 256 * DIV + 3, 1'b1);
        t_ovf(1'b1, 1'b0, 8190, 8196, 1'b1);
        t_ovf(1'b1, 1'b1, 9000, 9000, 1'b0);
        t_service();
        t_modes();
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
